// ### smsp_if.sv
// smsp_if: management clock, data line and interrupt between the two ends
// assumes: the pull-ups are modelled here; levels resolved here
`timescale 1ns/1ps
`default_nettype none
interface smsp_if;
  logic mdc;
  logic mdio_mgr_o;
  logic mdio_mgr_oe;
  logic mdio_phy_o;
  logic mdio_phy_oe;
  logic int_oe;
  logic mdio_i;
  logic int_n_i;
  // pull-up: line reads one unless someone drives
  assign mdio_i = (mdio_mgr_oe ? mdio_mgr_o : 1'b1) & (mdio_phy_oe ? mdio_phy_o : 1'b1);
  assign int_n_i = ~int_oe;
  modport phy (input mdc, input mdio_i, output mdio_phy_o, output mdio_phy_oe, output int_oe);
  modport mgr (output mdc, input mdio_i, output mdio_mgr_o, output mdio_mgr_oe, input int_n_i);
endinterface : smsp_if
`default_nettype wire

// ### smsp_mgr.sv
// smsp_mgr: station manager end; makes mdc and runs one frame per request
// assumes: caller holds req until ack; user side on sys_clk
`timescale 1ns/1ps
`default_nettype none
module smsp_mgr #(
  parameter int PRE_LEN = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // link
  smsp_if.mgr link,
  // request
  input wire logic req,
  input wire logic req_write,
  input wire logic [4:0] req_phy,
  input wire logic [4:0] req_reg,
  input wire logic [15:0] req_wdata,
  // answer
  output logic ack,
  output logic [15:0] rdata,
  output logic irq_pending
);
  typedef enum logic [1:0] {MG_IDLE, MG_RUN} smsp_mg_e;
  smsp_mg_e st_q;
  logic [7:0] div_q;
  logic mdc_q;
  logic [6:0] bit_q;
  logic [31:0] frm_q;
  logic wr_q;
  logic [15:0] rd_q;
  logic ack_q;
  logic init_q;
  wire logic int_s;
  wire logic mdio_s;
  smsp_sync #(.RST_VAL(1'b1)) u_int (.sys_clk(sys_clk), .rst(rst), .async_in(link.int_n_i),
    .sync_out(int_s), .rise());
  smsp_sync #(.RST_VAL(1'b1)) u_dat (.sys_clk(sys_clk), .rst(rst), .async_in(link.mdio_i),
    .sync_out(mdio_s), .rise());
  // divider keeps mdc at or below its limit
  wire logic half_tick = (div_q == 8'(smsp_pkg::MDC_HALF - 1));
  wire logic fall_tick = half_tick & mdc_q;
  wire logic rise_tick = half_tick & ~mdc_q;
  localparam int TOTAL = PRE_LEN + 32;
  wire logic frame_end = (bit_q == 7'(TOTAL));
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_q <= 8'h00;
      mdc_q <= 1'b0;
    end else begin
      div_q <= half_tick ? 8'h00 : div_q + 8'h01;
      if (half_tick) mdc_q <= ~mdc_q;
    end
  end
  // bit index counts mdc falls; data changes on fall, stable at rise
  wire logic [6:0] fi = bit_q - 7'(PRE_LEN);
  wire logic in_ta1 = (fi == 7'd14);
  wire logic in_rd = (fi >= 7'd14) && (fi < 7'd32);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= MG_IDLE;
      bit_q <= 7'd0;
      frm_q <= 32'h0000_0000;
      wr_q <= 1'b0;
      rd_q <= 16'h0000;
      ack_q <= 1'b0;
      init_q <= 1'b0;
    end else begin
      ack_q <= 1'b0;
      case (st_q)
        MG_IDLE: begin
          if (fall_tick && !init_q) bit_q <= bit_q + 7'd1; // ones at idle
          if (bit_q >= 7'(smsp_pkg::INIT_ONES)) init_q <= 1'b1;
          if (init_q && req && fall_tick && !ack_q) begin
            st_q <= MG_RUN;
            bit_q <= 7'd0;
            wr_q <= req_write;
            frm_q <= {smsp_pkg::SFD_PAT, req_write ? smsp_pkg::OP_WRITE : smsp_pkg::OP_READ,
              req_phy, req_reg, 2'b10, req_wdata}; // MSB first
          end
        end
        MG_RUN: begin
          if (rise_tick && !wr_q && fi >= 7'd16 && fi < 7'd32)
            rd_q <= {rd_q[14:0], mdio_s}; // sampled on mdc rise
          if (fall_tick) begin
            bit_q <= bit_q + 7'd1;
            if (bit_q >= 7'(PRE_LEN)) frm_q <= {frm_q[30:0], 1'b1};
            if (frame_end) begin
              st_q <= MG_IDLE;
              ack_q <= 1'b1;
            end
          end
        end
        default: st_q <= MG_IDLE;
      endcase
    end
  end
  wire logic drive = (st_q == MG_RUN) && !frame_end && !(!wr_q && in_rd);
  assign link.mdc = mdc_q;
  assign link.mdio_mgr_oe = drive;
  assign link.mdio_mgr_o = (bit_q < 7'(PRE_LEN)) ? 1'b1 : frm_q[31];
  assign ack = ack_q;
  assign rdata = rd_q;
  assign irq_pending = ~int_s;
  wire logic unused_ta = in_ta1;
endmodule : smsp_mgr
`default_nettype wire

// ### smsp_phy.sv
// smsp_phy: management serial slave end with register file and interrupt pin
// assumes: mdc and mdio arrive asynchronously; manager owns the clock
// Functional notes
// - sample incoming data on mdc rising edge
// - launch read data on mdc rising edge
// - manager keeps mdc at most 12.5 MHz
// - 32-bit frame, optional preamble
// - manager gives two ones before first frame
// - release data line while idle
// - preamble optional, any length of ones
// - start pattern 01, else ignore until preamble
// - opcode 10 read, 01 write, else ignore
// - answer only matching 5-bit PHY address
// - five-bit register address follows
// - read turnaround: float, then drive zero
// - read data held edge to edge
// - manager holds write data around edge
// - 32 registers of 16 bits
// - register 31 selects page
// - registers 13/14 give indirect access
// - interrupt only when 25.15 set
// - interrupt pin open-drain active low
// - serial port stays alive in low power
// - reading 26 clears status, drops interrupt
`timescale 1ns/1ps
`default_nettype none
module smsp_phy #(
  parameter logic [4:0] PHY_ADDR = 5'h00,
  parameter int NUM_PAGES = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // link
  smsp_if.phy link,
  // port events and power state
  input wire logic [3:0] port_event,
  input wire logic low_power
);
  typedef enum logic [2:0] {SM_HUNT, SM_SFD, SM_HDR, SM_TA, SM_RDATA, SM_WDATA, SM_SKIP} smsp_st_e;
  smsp_st_e st_q;
  logic [3:0] cnt_q;
  logic [11:0] hdr_q;
  logic [15:0] sh_q;
  logic [15:0] regs_q [smsp_pkg::NUM_REGS];
  logic [15:0] page_regs_q [NUM_PAGES-1:1][smsp_pkg::NUM_REGS];
  logic [15:0] ext_q [smsp_pkg::EXT_DEPTH];
  logic [15:0] int_stat_q;
  logic pd_q;
  logic oe_q;
  logic do_q;
  wire logic mdc_rise;
  wire logic mdio_s;
  // low_power deliberately gates nothing here: the port stays alive
  smsp_sync #(.RST_VAL(1'b1)) u_mdc (.sys_clk(sys_clk), .rst(rst), .async_in(link.mdc),
    .sync_out(), .rise(mdc_rise));
  smsp_sync #(.RST_VAL(1'b1)) u_mdio (.sys_clk(sys_clk), .rst(rst), .async_in(link.mdio_i),
    .sync_out(mdio_s), .rise());
  // after twelve header bits: op in [11:10], phy address [9:5], register [4:0]
  wire logic [1:0] op_w = hdr_q[11:10];
  wire logic [4:0] padr_w = hdr_q[9:5];
  wire logic [4:0] radr_w = hdr_q[4:0];
  wire logic [4:0] cur_radr = {hdr_q[3:0], mdio_s};
  wire logic addr_ok = (padr_w == PHY_ADDR);
  // checks made while the last bit of a field is still on the line
  wire logic [1:0] op_now = {hdr_q[0], mdio_s};
  wire logic op_ok = (op_now == smsp_pkg::OP_READ) || (op_now == smsp_pkg::OP_WRITE);
  wire logic padr_now_ok = (hdr_q[8:4] == PHY_ADDR);
  wire logic [1:0] page_w = regs_q[smsp_pkg::REG_PAGE][smsp_pkg::PAGE_W-1:0];
  wire logic ext_sel = (radr_w == smsp_pkg::REG_MMD_DATA);
  wire logic [3:0] ext_idx = regs_q[smsp_pkg::REG_MMD_CTRL][3:0];
  wire logic is_pg_reg = (radr_w == smsp_pkg::REG_PAGE);
  wire logic page_hit = page_w != 2'd0 && !is_pg_reg && 32'(page_w) < NUM_PAGES;
  // read mux: page select, indirect window, clear-on-read status
  logic [15:0] rd_val;
  always_comb begin
    if (ext_sel) begin
      rd_val = ext_q[ext_idx];
    end else if (radr_w == smsp_pkg::REG_INT_STAT) begin
      rd_val = int_stat_q;
    end else if (page_hit) begin
      rd_val = page_regs_q[page_w][radr_w];
    end else begin
      rd_val = regs_q[radr_w];
    end
  end
  wire logic any_evt = |port_event;
  wire logic rd_clr = mdc_rise && st_q == SM_TA && cnt_q == 4'd1 && addr_ok
    && radr_w == smsp_pkg::REG_INT_STAT && op_w == smsp_pkg::OP_READ;
  wire logic wr_commit = mdc_rise && st_q == SM_WDATA && cnt_q == 4'd15;
  wire logic [15:0] wr_val = {sh_q[14:0], mdio_s};
  // frame decoder, everything stepped on mdc rising edges
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= SM_SKIP;
      cnt_q <= 4'd0;
      hdr_q <= 12'h000;
      sh_q <= 16'h0000;
      oe_q <= 1'b0;
      do_q <= 1'b1;
    end else if (mdc_rise) begin
      case (st_q)
        SM_SKIP: begin
          oe_q <= 1'b0; // never drive while ignoring bits
          do_q <= 1'b1;
          if (mdio_s) st_q <= SM_HUNT; // preamble one re-arms
        end
        SM_HUNT: begin
          oe_q <= 1'b0;
          if (!mdio_s) st_q <= SM_SFD; // start bit, no preamble needed
        end
        SM_SFD: begin
          st_q <= mdio_s ? SM_HDR : SM_SKIP;
          cnt_q <= 4'd0;
        end
        SM_HDR: begin
          hdr_q <= {hdr_q[10:0], mdio_s}; // MSB first
          cnt_q <= cnt_q + 4'd1;
          if (cnt_q == 4'd1 && !op_ok) begin
            st_q <= SM_SKIP;
          end else if (cnt_q == 4'd11) begin
            if (!padr_now_ok) st_q <= SM_SKIP;
            else st_q <= SM_TA;
            cnt_q <= 4'd0;
          end
        end
        SM_TA: begin
          cnt_q <= cnt_q + 4'd1;
          if (cnt_q == 4'd0 && op_w == smsp_pkg::OP_READ) begin
            oe_q <= 1'b1; // first TA floats, second driven zero
            do_q <= 1'b0;
          end else if (cnt_q == 4'd1) begin
            cnt_q <= 4'd0;
            if (op_w == smsp_pkg::OP_READ) begin
              st_q <= SM_RDATA;
              sh_q <= {rd_val[14:0], 1'b0};
              do_q <= rd_val[15];
            end else begin
              st_q <= SM_WDATA;
            end
          end
        end
        SM_RDATA: begin
          cnt_q <= cnt_q + 4'd1;
          do_q <= sh_q[15]; // each bit held one mdc period
          sh_q <= {sh_q[14:0], 1'b0};
          if (cnt_q == 4'd15) begin
            oe_q <= 1'b0;
            do_q <= 1'b1;
            st_q <= SM_HUNT;
          end
        end
        SM_WDATA: begin
          sh_q <= wr_val;
          cnt_q <= cnt_q + 4'd1;
          if (cnt_q == 4'd15) st_q <= SM_HUNT;
        end
        default: st_q <= SM_SKIP;
      endcase
    end
  end
  // unused radr helper kept out of logic
  wire logic unused_ok = ^cur_radr;
  // register file, written only on the sixteenth data bit
  wire logic we_ext = wr_commit && ext_sel;
  wire logic we_page = wr_commit && !ext_sel && page_hit;
  wire logic we_base = wr_commit && !ext_sel && !page_hit;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < smsp_pkg::NUM_REGS; i++) regs_q[i] <= smsp_pkg::REG_RESET;
    end else if (we_base) begin
      regs_q[radr_w] <= wr_val;
    end
  end
  // paged copies; page 0 is the base set above
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int p = 1; p < NUM_PAGES; p++)
        for (int i = 0; i < smsp_pkg::NUM_REGS; i++) page_regs_q[p][i] <= smsp_pkg::REG_RESET;
    end else if (we_page) begin
      page_regs_q[page_w][radr_w] <= wr_val;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < smsp_pkg::EXT_DEPTH; i++) ext_q[i] <= smsp_pkg::REG_RESET;
    end else if (we_ext) begin
      ext_q[ext_idx] <= wr_val;
    end
  end
  // sticky event bit: a new event wins over the read clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      int_stat_q <= 16'h0000;
      pd_q <= 1'b0;
    end else begin
      pd_q <= low_power;
      if (any_evt) int_stat_q[smsp_pkg::INT_EVT_BIT] <= 1'b1;
      else if (rd_clr) int_stat_q <= 16'h0000;
    end
  end
  wire logic int_act = int_stat_q[smsp_pkg::INT_EVT_BIT]
    & regs_q[smsp_pkg::REG_INT_MASK][smsp_pkg::INT_EN_BIT];
  assign link.int_oe = int_act; // pulls low only, else floats
  assign link.mdio_phy_oe = oe_q;
  assign link.mdio_phy_o = do_q;
  wire logic unused_pd = pd_q ^ unused_ok;
endmodule : smsp_phy
`default_nettype wire

// ### smsp_pkg.sv
// smsp_pkg: constants shared by both ends of the management serial link
// assumes: nothing beyond a SystemVerilog compiler
package smsp_pkg;
  localparam logic [1:0] SFD_PAT = 2'b01;
  localparam logic [1:0] OP_READ = 2'b10;
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int NUM_REGS = 32;
  localparam int PAGE_W = 2;
  localparam logic [4:0] REG_MMD_CTRL = 5'h0D;
  localparam logic [4:0] REG_MMD_DATA = 5'h0E;
  localparam logic [4:0] REG_INT_MASK = 5'h19;
  localparam logic [4:0] REG_INT_STAT = 5'h1A;
  localparam logic [4:0] REG_PAGE = 5'h1F;
  localparam int INT_EN_BIT = 15;
  localparam int INT_EVT_BIT = 9;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam int EXT_DEPTH = 16;
  localparam int CLK_MHZ_X10 = 1000;
  localparam int MDC_MAX_MHZ_X10 = 125;
  // half period in sys_clk cycles, rounded up so mdc never exceeds its limit
  localparam int MDC_HALF = (CLK_MHZ_X10 + 2 * MDC_MAX_MHZ_X10 - 1) / (2 * MDC_MAX_MHZ_X10);
  localparam int INIT_ONES = 2;
endpackage : smsp_pkg

// ### smsp_props.sv
// smsp_props: timing checks on the management serial link wires
// assumes: instantiated beside the link interface, sys_clk domain, rst sync high
`timescale 1ns/1ps
`default_nettype none
module smsp_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // link
  input wire logic mdc,
  input wire logic mdio_mgr_o,
  input wire logic mdio_mgr_oe,
  input wire logic mdio_phy_o,
  input wire logic mdio_phy_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic mdc_q;
  logic [3:0] since_q;
  logic [1:0] init_q;
  logic [7:0] oe_q;
  wire mdc_rise = mdc & ~mdc_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mdc_q <= 1'b0;
      since_q <= 4'hF;
      init_q <= 2'h0;
      oe_q <= 8'h00;
    end else begin
      mdc_q <= mdc;
      since_q <= mdc_rise ? 4'h0 : (since_q == 4'hF ? since_q : since_q + 4'h1);
      init_q <= (mdc_rise && !mdio_mgr_oe && init_q != 2'h2) ? init_q + 2'h1 : init_q;
      oe_q <= mdio_phy_oe ? oe_q + 8'h01 : 8'h00;
    end
  end
  // phy output moves: first drive or a new bit while driving
  sequence phy_launch;
    $rose(mdio_phy_oe) || (mdio_phy_oe && $changed(mdio_phy_o));
  endsequence
  a_mdc_half_min: assert property ($changed(mdc) |=> $stable(mdc) [*3])
    else $error("mdc half period shorter than four clocks");
  a_mgr_hold_high: assert property (mdc && $past(mdc) && mdio_mgr_oe |-> $stable(mdio_mgr_o))
    else $error("manager data moved while mdc high");
  a_init_ones: assert property (mdio_mgr_oe |-> init_q == 2'h2)
    else $error("manager drove before two idle mdc pulses");
  a_no_contention: assert property (!(mdio_mgr_oe && mdio_phy_oe))
    else $error("both ends drive the data line");
  a_ta_zero: assert property ($rose(mdio_phy_oe) |-> !mdio_phy_o)
    else $error("first driven turnaround bit is not zero");
  a_launch_rise: assert property (phy_launch |-> since_q <= 4'h4)
    else $error("phy launched data away from mdc rise");
  a_read_burst: assert property ($fell(mdio_phy_oe) |-> oe_q >= 8'd130 && oe_q <= 8'd141)
    else $error("phy drive window not seventeen bit times");
  a_release_quiet: assert property ($fell(mdio_phy_oe) |=> !mdio_phy_oe [*8])
    else $error("phy drove again right after release");
  c_read_done: cover property ($fell(mdio_phy_oe));
endmodule : smsp_props
`default_nettype wire

// ### smsp_sync.sv
// smsp_sync: two-flop synchroniser with rising-edge detect on the output
// assumes: sys_clk domain, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module smsp_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // async in, synced out
  input wire logic async_in,
  output logic sync_out,
  output logic rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign sync_out = s2_q;
  assign rise = s2_q & ~s3_q;
endmodule : smsp_sync
`default_nettype wire

// ### tb_smsp.sv
// tb_smsp: both link ends face to face; frames driven from the manager user side
// assumes: phy answers at address 5'h0B; no malformed frames are generated
`timescale 1ns/1ps
`default_nettype none
module tb_smsp;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic [4:0] req_phy = 5'h00;
  logic [4:0] req_reg = 5'h00;
  logic [15:0] req_wdata = 16'h0000;
  logic ack;
  logic [15:0] rdata;
  logic irq_pending;
  logic [3:0] port_event = 4'h0;
  logic low_power = 1'b0;
  logic [15:0] rd;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  localparam logic [4:0] MY_PHY = 5'h0B;
  smsp_if link ();
  smsp_phy #(.PHY_ADDR(MY_PHY)) u_smsp_phy (.sys_clk(sys_clk), .rst(rst), .link(link),
    .port_event(port_event), .low_power(low_power));
  smsp_mgr u_smsp_mgr (.sys_clk(sys_clk), .rst(rst), .link(link), .req(req),
    .req_write(req_write), .req_phy(req_phy), .req_reg(req_reg), .req_wdata(req_wdata),
    .ack(ack), .rdata(rdata), .irq_pending(irq_pending));
  smsp_props u_smsp_props (.sys_clk(sys_clk), .rst(rst), .mdc(link.mdc),
    .mdio_mgr_o(link.mdio_mgr_o), .mdio_mgr_oe(link.mdio_mgr_oe),
    .mdio_phy_o(link.mdio_phy_o), .mdio_phy_oe(link.mdio_phy_oe));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // request held until ack, released at the ack edge
  task automatic frame(input logic w, input logic [4:0] ph, input logic [4:0] rg,
                       input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    req <= 1'b1;
    req_write <= w;
    req_phy <= ph;
    req_reg <= rg;
    req_wdata <= wd;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      bad_count++;
      $display("[FAIL] ack expected 1 seen timeout");
      complete_run();
    end
    rd = rdata;
    req <= 1'b0;
  endtask : frame
  task automatic wr(input logic [4:0] rg, input logic [15:0] wd);
    frame(1'b1, MY_PHY, rg, wd);
  endtask : wr
  task automatic rd_chk(input logic [4:0] ph, input logic [4:0] rg, input logic [15:0] exp);
    frame(1'b0, ph, rg, 16'h0000);
    chk("read data", exp, rd);
  endtask : rd_chk
  task automatic event_pulse();
    @(posedge sys_clk);
    port_event <= 4'h4;
    repeat (3) @(posedge sys_clk);
    port_event <= 4'h0;
    repeat (12) @(posedge sys_clk);
  endtask : event_pulse
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      $display("[FAIL] run expected done seen timeout");
      complete_run();
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    // boundary registers, MSB-first pattern readback
    wr(5'h00, 16'hA5C3);
    wr(5'h1E, 16'h8001);
    rd_chk(MY_PHY, 5'h00, 16'hA5C3);
    rd_chk(MY_PHY, 5'h1E, 16'h8001);
    $display("test basic done");
    // other address: no write lands, nobody answers so line reads ones
    frame(1'b1, 5'h0A, 5'h00, 16'h1234);
    rd_chk(5'h0A, 5'h00, 16'hFFFF);
    rd_chk(MY_PHY, 5'h00, 16'hA5C3);
    $display("test address done");
    // page select keeps page 0 content apart
    wr(5'h05, 16'h5A5A);
    wr(5'h1F, 16'h0001);
    wr(5'h05, 16'h1111);
    rd_chk(MY_PHY, 5'h1F, 16'h0001);
    rd_chk(MY_PHY, 5'h05, 16'h1111);
    wr(5'h1F, 16'h0000);
    rd_chk(MY_PHY, 5'h05, 16'h5A5A);
    $display("test page done");
    // indirect bank through 13/14
    wr(5'h0D, 16'h0003);
    wr(5'h0E, 16'hBEEF);
    wr(5'h0D, 16'h0004);
    wr(5'h0E, 16'h0F0F);
    wr(5'h0D, 16'h0003);
    rd_chk(MY_PHY, 5'h0E, 16'hBEEF);
    $display("test indirect done");
    // interrupt in low power: enabled, cleared by read, then masked
    low_power <= 1'b1;
    wr(5'h19, 16'h8000);
    event_pulse();
    chk("irq enabled", 16'h0001, {15'h0000, irq_pending});
    rd_chk(MY_PHY, 5'h1A, 16'h0200);
    repeat (12) @(posedge sys_clk);
    chk("irq after clear", 16'h0000, {15'h0000, irq_pending});
    wr(5'h19, 16'h0000);
    event_pulse();
    chk("irq masked", 16'h0000, {15'h0000, irq_pending});
    rd_chk(MY_PHY, 5'h1A, 16'h0200);
    rd_chk(MY_PHY, 5'h1A, 16'h0000);
    $display("test interrupt done");
    complete_run();
  end
endmodule : tb_smsp
`default_nettype wire
